//--- design/irq_vector_pkg.sv
// Package with offsets, field positions, reset values and vector addresses of the vectoring block.
package irq_vector_pkg;

    // =====================================================================
    // Widths and sizes
    // =====================================================================
    localparam int SRC_COUNT   = 8;
    localparam int PC_W        = 12;
    localparam int STACK_DEPTH = 8;
    localparam int DEPTH_W     = 4;
    localparam int ADR_W       = 8;

    // =====================================================================
    // Register byte offsets on the bus
    // =====================================================================
    localparam logic [ADR_W-1:0] OFS_FLAGS   = 8'h00;
    localparam logic [ADR_W-1:0] OFS_ENABLES = 8'h04;
    localparam logic [ADR_W-1:0] OFS_CTRL    = 8'h08;
    localparam logic [ADR_W-1:0] OFS_STATUS  = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_ARMED   = 8'h10;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int SRC_TC0  = 0;
    localparam int SRC_TC1  = 1;
    localparam int SRC_TC2  = 2;
    localparam int SRC_WIDE = 3;
    localparam int SRC_CONV = 4;
    localparam int SRC_SYNC = 5;
    localparam int SRC_ARX  = 6;
    localparam int SRC_ATX  = 7;

    localparam int CTRL_GIE_BIT    = 0;
    localparam int STAT_DEPTH_LSB  = 0;
    localparam int STAT_PEND_BIT   = 4;
    localparam int STAT_FULL_BIT   = 5;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [SRC_COUNT-1:0] FLAGS_RST   = 8'h00;
    localparam logic [SRC_COUNT-1:0] ENABLES_RST = 8'h00;
    localparam logic                 GIE_RST     = 1'b0;
    localparam logic [DEPTH_W-1:0]   DEPTH_RST   = 4'h0;
    localparam logic [PC_W-1:0]      PC_RST      = 12'h000;

    // =====================================================================
    // Vector addresses, indexed by source position
    // =====================================================================
    localparam logic [PC_W-1:0] VEC_TC0  = 12'h00C;
    localparam logic [PC_W-1:0] VEC_TC1  = 12'h00D;
    localparam logic [PC_W-1:0] VEC_TC2  = 12'h00E;
    localparam logic [PC_W-1:0] VEC_WIDE = 12'h00F;
    localparam logic [PC_W-1:0] VEC_CONV = 12'h010;
    localparam logic [PC_W-1:0] VEC_SYNC = 12'h011;
    localparam logic [PC_W-1:0] VEC_ARX  = 12'h013;
    localparam logic [PC_W-1:0] VEC_ATX  = VEC_ARX + 12'h001;

    localparam logic [PC_W-1:0] VEC_TABLE [SRC_COUNT] = '{
        VEC_TC0, VEC_TC1, VEC_TC2, VEC_WIDE, VEC_CONV, VEC_SYNC, VEC_ARX, VEC_ATX
    };

endpackage : irq_vector_pkg

//--- design/irq_vectoring.sv
// Peripheral interrupt request flags, enables and vectoring with return-address stack.
//
// Functional notes
// - Timer/counter 0 wrap always sets its flag.
// - Timer/counter 1 wrap always sets its flag.
// - Timer/counter 2 wrap always sets its flag.
// - Wide timer overflow always sets its flag.
// - Conversion done always sets its flag.
// - Sync serial transfer done always sets flag.
// - Async receive/transmit done set matching flag.
// - Enabled source event diverts execution to vector.
// - Disabled source: flag set, no vectoring.
// - Flag raised while disabled never vectors later.
// - Timer/counter 0 vector is 0CH.
// - Timer/counter 1 vector is 0DH.
// - Timer/counter 2 vector is 0EH.
// - Wide timer vector is 0FH.
// - Conversion done vector is 10H.
// - Sync serial vector is 11H.
// - Async receive vector is 13H.
// - Vectoring needs global enable set as well.
// - Taking interrupt loads vector, pushes return address; here no push once the stack holds 8 entries.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns

module irq_vectoring
    import irq_vector_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 tmr_cnt0_wrap_i,
    input  wire logic                 tmr_cnt1_wrap_i,
    input  wire logic                 tmr_cnt2_wrap_i,
    input  wire logic                 wide_timer_overflow_i,
    input  wire logic                 conversion_done_i,
    input  wire logic                 sync_serial_done_i,
    input  wire logic                 async_rx_done_i,
    input  wire logic                 async_tx_done_i,
    input  wire logic                 irq_take_i,
    input  wire logic                 irq_return_i,
    input  wire logic [PC_W-1:0]      return_pc_i,
    output logic                      irq_request_o,
    output logic      [PC_W-1:0]      irq_vector_o,
    output logic                      pc_load_o,
    output logic      [PC_W-1:0]      pc_value_o
);

    // =====================================================================
    // Source events
    // =====================================================================
    logic [SRC_COUNT-1:0] event_vec;

    always_comb begin
        event_vec                = '0;
        event_vec[SRC_TC0]  = tmr_cnt0_wrap_i;
        event_vec[SRC_TC1]  = tmr_cnt1_wrap_i;
        event_vec[SRC_TC2]  = tmr_cnt2_wrap_i;
        event_vec[SRC_WIDE] = wide_timer_overflow_i;
        event_vec[SRC_CONV] = conversion_done_i;
        event_vec[SRC_SYNC] = sync_serial_done_i;
        event_vec[SRC_ARX]  = async_rx_done_i;
        event_vec[SRC_ATX]  = async_tx_done_i;
    end

    // =====================================================================
    // Bus slave
    // =====================================================================
    // The answer comes one cycle after the request is seen; a write takes
    // effect at the edge where the master samples the acknowledge, so a held
    // request is written exactly once.
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        bus_req;
    logic        bus_wr;
    logic        wr_flags;
    logic        wr_enables;
    logic        wr_ctrl;

    logic [SRC_COUNT-1:0] flags_reg;
    logic [SRC_COUNT-1:0] flags_next;
    logic [SRC_COUNT-1:0] enables_reg;
    logic [SRC_COUNT-1:0] enables_next;
    logic [SRC_COUNT-1:0] armed_reg;
    logic [SRC_COUNT-1:0] armed_next;
    logic                 gie_reg;
    logic                 gie_next;
    logic [DEPTH_W-1:0]   depth_reg;
    logic [DEPTH_W-1:0]   depth_next;
    logic                 req_reg;

    assign bus_req    = wb_cyc_i && wb_stb_i;
    assign bus_wr     = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
    assign wr_flags   = bus_wr && (wb_adr_i == OFS_FLAGS);
    assign wr_enables = bus_wr && (wb_adr_i == OFS_ENABLES);
    assign wr_ctrl    = bus_wr && (wb_adr_i == OFS_CTRL);

    always_comb begin
        ack_next   = bus_req && !ack_reg;
        rdata_next = rdata_reg;
        if (bus_req && !ack_reg) begin
            rdata_next = '0;
            case (wb_adr_i)
                OFS_FLAGS: begin
                    rdata_next[SRC_COUNT-1:0] = flags_reg;
                end
                OFS_ENABLES: begin
                    rdata_next[SRC_COUNT-1:0] = enables_reg;
                end
                OFS_CTRL: begin
                    rdata_next[CTRL_GIE_BIT] = gie_reg;
                end
                OFS_STATUS: begin
                    rdata_next[STAT_DEPTH_LSB +: DEPTH_W] = depth_reg;
                    rdata_next[STAT_PEND_BIT]            = req_reg;
                    rdata_next[STAT_FULL_BIT]            = (depth_reg == DEPTH_W'(STACK_DEPTH));
                end
                OFS_ARMED: begin
                    rdata_next[SRC_COUNT-1:0] = armed_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
        end else if (ce_i) begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // =====================================================================
    // Core handshake qualifiers
    // =====================================================================
    logic             take;
    logic             give_back;
    logic [2:0]       src_reg;
    logic [PC_W-1:0]  vector_reg;

    // A take and a return in the same cycle cannot both be honoured; the take
    // wins because losing a vector is worse than delaying a return.
    assign take      = irq_take_i && req_reg;
    assign give_back = irq_return_i && !take && (depth_reg != '0);

    // =====================================================================
    // Flags, enables and arming
    // =====================================================================
    // The armed bit remembers that a flag was raised while its source was
    // enabled. Only armed sources may vector, so a stale flag left from a
    // disabled period stays quiet after the enable is set.
    always_comb begin
        flags_next   = flags_reg;
        enables_next = enables_reg;
        armed_next   = armed_reg;
        if (wr_flags) begin
            flags_next = wb_dat_i[SRC_COUNT-1:0];
        end
        if (wr_enables) begin
            enables_next = wb_dat_i[SRC_COUNT-1:0];
        end
        armed_next = armed_next & flags_next;
        if (take) begin
            armed_next[src_reg] = 1'b0;
        end
        flags_next = flags_next | event_vec;
        armed_next = armed_next | (event_vec & enables_reg);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg   <= FLAGS_RST;
            enables_reg <= ENABLES_RST;
            armed_reg   <= '0;
        end else if (ce_i) begin
            flags_reg   <= flags_next;
            enables_reg <= enables_next;
            armed_reg   <= armed_next;
        end
    end

    // =====================================================================
    // Global enable, request and vector selection
    // =====================================================================
    logic             req_next;
    logic [2:0]       src_next;
    logic [PC_W-1:0]  vector_next;

    always_comb begin
        gie_next = gie_reg;
        if (wr_ctrl) begin
            gie_next = wb_dat_i[CTRL_GIE_BIT];
        end
        // Entry masks further interrupts until the service routine returns or sets the global enable by a control write.
        if (take) begin
            gie_next = 1'b0;
        end else if (give_back) begin
            gie_next = 1'b1;
        end
        src_next = src_reg;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (armed_next[i]) begin
                src_next = 3'(i);
            end
        end
        vector_next = VEC_TABLE[src_next];
        req_next    = gie_next && (armed_next != '0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gie_reg    <= GIE_RST;
            req_reg    <= 1'b0;
            src_reg    <= '0;
            vector_reg <= PC_RST;
        end else if (ce_i) begin
            gie_reg    <= gie_next;
            req_reg    <= req_next;
            src_reg    <= src_next;
            vector_reg <= vector_next;
        end
    end

    assign irq_request_o = req_reg;
    assign irq_vector_o  = vector_reg;

    // =====================================================================
    // Return-address stack and program counter load
    // =====================================================================
    // When the stack is full a further entry still vectors but its return
    // address is dropped; software must bound its nesting.
    logic [PC_W-1:0] stack_mem  [STACK_DEPTH];
    logic [PC_W-1:0] stack_next [STACK_DEPTH];
    logic            pc_load_reg;
    logic            pc_load_next;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;

    always_comb begin
        stack_next   = stack_mem;
        depth_next   = depth_reg;
        pc_load_next = 1'b0;
        pc_next      = pc_reg;
        if (take) begin
            pc_load_next = 1'b1;
            pc_next      = vector_reg;
            if (depth_reg != DEPTH_W'(STACK_DEPTH)) begin
                stack_next[depth_reg[2:0]] = return_pc_i;
                depth_next                 = depth_reg + 4'h1;
            end
        end else if (give_back) begin
            pc_load_next = 1'b1;
            pc_next      = stack_mem[3'(depth_reg - 4'h1)];
            depth_next   = depth_reg - 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            depth_reg   <= DEPTH_RST;
            pc_load_reg <= 1'b0;
            pc_reg      <= PC_RST;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= PC_RST;
            end
        end else if (ce_i) begin
            depth_reg   <= depth_next;
            pc_load_reg <= pc_load_next;
            pc_reg      <= pc_next;
            stack_mem   <= stack_next;
        end
    end

    assign pc_load_o  = pc_load_reg;
    assign pc_value_o = pc_reg;

endmodule : irq_vectoring

//--- testbench/irq_vectoring_props.sv
// Checker with concurrent assertions on the ports of the vectoring block.
`timescale 1ns/1ns
module irq_vectoring_props
    import irq_vector_pkg::*;
(
    input logic            clk_i,
    input logic            rst_i,
    input logic            ce_i,
    input logic            wb_cyc_i,
    input logic            wb_stb_i,
    input logic            wb_we_i,
    input logic            wb_ack_o,
    input logic [31:0]     wb_dat_o,
    input logic            tmr_cnt0_wrap_i,
    input logic            tmr_cnt1_wrap_i,
    input logic            tmr_cnt2_wrap_i,
    input logic            wide_timer_overflow_i,
    input logic            conversion_done_i,
    input logic            sync_serial_done_i,
    input logic            async_rx_done_i,
    input logic            async_tx_done_i,
    input logic            irq_take_i,
    input logic            irq_return_i,
    input logic            irq_request_o,
    input logic [PC_W-1:0] irq_vector_o,
    input logic            pc_load_o,
    input logic [PC_W-1:0] pc_value_o
);
    logic cause;
    logic taken;
    // A request may only rise after an event, a register write or a return.
    assign cause = tmr_cnt0_wrap_i | tmr_cnt1_wrap_i | tmr_cnt2_wrap_i | wide_timer_overflow_i
        | conversion_done_i | sync_serial_done_i | async_rx_done_i | async_tx_done_i
        | (wb_cyc_i & wb_we_i & wb_ack_o) | irq_return_i;
    assign taken = irq_take_i & irq_request_o & ce_i & ~irq_return_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("Bus request was not acknowledged in the next cycle.");
    AST_ACK_ONE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("Acknowledge lasted more than one cycle.");
    AST_TAKE_LOAD: assert property (taken |=> pc_load_o && pc_value_o == $past(irq_vector_o))
        else $error("Take did not load the vector.");
    AST_TAKE_DROP: assert property (taken |=> !irq_request_o)
        else $error("Request stayed up after a take.");
    AST_LOAD_CAUSE: assert property (pc_load_o |-> $past(irq_take_i) || $past(irq_return_i))
        else $error("Program counter load without a take or return.");
    AST_VEC_SET: assert property (irq_request_o |-> irq_vector_o inside {12'h00C, 12'h00D,
        12'h00E, 12'h00F, 12'h010, 12'h011, 12'h013, 12'h014})
        else $error("Vector outside the fixed vector set.");
    AST_REQ_CAUSE: assert property ($rose(irq_request_o) |-> $past(cause) || $past(cause, 2))
        else $error("Request rose without a cause.");
    AST_RST_IDLE: assert property ($fell(rst_i) |-> !irq_request_o && !pc_load_o && !wb_ack_o
        && pc_value_o == 12'h000 && irq_vector_o == 12'h000)
        else $error("Outputs not idle after reset.");
    AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("Read data upper bits not zero.");
endmodule : irq_vectoring_props
bind irq_vectoring irq_vectoring_props irq_vectoring_props_i (.*);

//--- testbench/core_model.sv
// Behavioural core sequencer that takes pending interrupts and returns from them.
`timescale 1ns/1ns
module core_model
    import irq_vector_pkg::*;
#(
    parameter logic [PC_W-1:0] RET_PC = 12'h5A5
)(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            irq_request_i,
    input  wire logic            ret_cmd_i,
    input  wire logic [3:0]      lag_i,
    output logic                 irq_take_o,
    output logic                 irq_return_o,
    output logic      [PC_W-1:0] return_pc_o
);
    logic [3:0] cnt_reg = 4'h0;
    // The address only counts with the take strobe, so it is scrambled otherwise.
    assign return_pc_o = irq_take_o ? RET_PC : ~RET_PC;
    always @(posedge clk_i) begin
        irq_return_o <= ret_cmd_i & ~rst_i;
        if (rst_i || !irq_request_i || irq_take_o) begin
            cnt_reg <= 4'h0;
            irq_take_o <= 1'h0;
        end else if (cnt_reg == lag_i) begin
            irq_take_o <= 1'h1;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule : core_model

//--- testbench/tb.sv
// Self-checking testbench for the interrupt vectoring block.
`timescale 1ns/1ns
module tb
    import irq_vector_pkg::*;
;
    localparam logic [PC_W-1:0] RET_PC = 12'h5A5;
    localparam logic [PC_W-1:0] VEC_EXP [8] = '{12'h00C, 12'h00D, 12'h00E, 12'h00F,
        12'h010, 12'h011, 12'h013, 12'h014};
    logic             clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ret_cmd;
    logic             irq_take_i, irq_return_i, irq_request_o, pc_load_o;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0]       wb_sel_i, lag;
    logic [31:0]      wb_dat_i, wb_dat_o;
    logic [7:0]       ev;
    logic [PC_W-1:0]  return_pc_i, irq_vector_o, pc_value_o;
    int               miscompares = 0;
    int               tests_run = 0;
    irq_vectoring irq_vectoring_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tmr_cnt0_wrap_i(ev[0]), .tmr_cnt1_wrap_i(ev[1]), .tmr_cnt2_wrap_i(ev[2]),
        .wide_timer_overflow_i(ev[3]), .conversion_done_i(ev[4]), .sync_serial_done_i(ev[5]),
        .async_rx_done_i(ev[6]), .async_tx_done_i(ev[7]), .irq_take_i(irq_take_i),
        .irq_return_i(irq_return_i), .return_pc_i(return_pc_i), .irq_request_o(irq_request_o),
        .irq_vector_o(irq_vector_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o));
    core_model #(.RET_PC(RET_PC)) core_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .irq_request_i(irq_request_o), .ret_cmd_i(ret_cmd), .lag_i(lag),
        .irq_take_o(irq_take_i), .irq_return_o(irq_return_i), .return_pc_o(return_pc_i));
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR at %0t: expected %h, got %h", $time, e, g);
        end
    endtask : chk
    // ====================================================================
    // Bus and stimulus helpers
    // A read compares against d, since write data means nothing on a read.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'h1};
        do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++n < 50);
        chk(32'h1, {31'h0, wb_ack_o});
        if (!we) chk(d, wb_dat_o);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic pulse(input logic [7:0] m);
        ev <= m;
        @(posedge clk_i);
        ev <= 8'h00;
        @(posedge clk_i);
    endtask : pulse
    task automatic wait_load(input logic [PC_W-1:0] e);
        int n = 0;
        do @(posedge clk_i); while (pc_load_o !== 1'h1 && ++n < 40);
        chk(32'h1, {31'h0, pc_load_o});
        chk({20'h0, e}, {20'h0, pc_value_o});
    endtask : wait_load
    task automatic serve();
        wb(1'h1, OFS_FLAGS, 32'h0);
        ret_cmd <= 1'h1;
        @(posedge clk_i);
        ret_cmd <= 1'h0;
        wait_load(RET_PC);
        wb(1'h0, OFS_STATUS, 32'h0);
    endtask : serve
    // ====================================================================
    // Scenarios
    task automatic t_reset();
        for (int a = 0; a <= 16; a += 4) wb(1'h0, a[7:0], 32'h0);
        wb(1'h1, OFS_STATUS, 32'hFF);
        wb(1'h1, 8'h40, 32'hFF);
        wb(1'h0, 8'h40, 32'h0);
        wb(1'h0, OFS_STATUS, 32'h0);
    endtask : t_reset
    task automatic t_disabled();
        wb(1'h1, OFS_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) pulse(8'h1 << i);
        wb(1'h0, OFS_FLAGS, 32'hFF);
        chk(32'h0, {31'h0, irq_request_o});
        wb(1'h1, OFS_ENABLES, 32'hFF);
        wb(1'h0, OFS_ARMED, 32'h0);
        chk(32'h0, {31'h0, irq_request_o});
        wb(1'h1, OFS_FLAGS, 32'h0);
        wb(1'h0, OFS_FLAGS, 32'h0);
    endtask : t_disabled
    // Odd sources let the core answer slowly, even ones promptly.
    task automatic t_vectors();
        for (int i = 0; i < 8; i++) begin
            lag <= i[0] ? 4'h5 : 4'h0;
            pulse(8'h1 << i);
            wait_load(VEC_EXP[i]);
            wb(1'h0, OFS_STATUS, 32'h1);
            wb(1'h0, OFS_FLAGS, 32'h1 << i);
            serve();
        end
    endtask : t_vectors
    task automatic t_global();
        wb(1'h1, OFS_CTRL, 32'h0);
        pulse(8'h01);
        chk(32'h0, {31'h0, irq_request_o});
        wb(1'h1, OFS_CTRL, 32'h1);
        wait_load(VEC_EXP[0]);
        serve();
    endtask : t_global
    // The event is raised only for the edge at which the clearing write lands, so the
    // flag can survive only if the event wins. A frozen clock enable must then hide an event.
    task automatic t_race();
        wb(1'h1, OFS_ENABLES, 32'h0);
        fork
            wb(1'h1, OFS_FLAGS, 32'h0);
            begin
                @(posedge wb_ack_o);
                ev <= 8'h20;
                @(posedge clk_i);
                ev <= 8'h00;
            end
        join
        wb(1'h0, OFS_FLAGS, 32'h20);
        ce_i <= 1'h0;
        pulse(8'h01);
        ce_i <= 1'h1;
        wb(1'h0, OFS_FLAGS, 32'h20);
    endtask : t_race
    initial begin
        {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, ret_cmd} = 6'h30;
        {wb_adr_i, wb_sel_i, wb_dat_i, ev, lag} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset();
        t_disabled();
        t_vectors();
        t_global();
        t_race();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end
endmodule : tb
